// ---- src/ethernet_mac_core_tx_core.sv ----
/*
  ethernet_mac_core: apb register file, transmit descriptor queue walker,
  address filter pairs and combined interrupt.
  assumes: one clock pclk; memory port answers a held request with a
  one-cycle mem_ack carrying mem_rdata; receive side reports its events on
  ext_event as one-cycle pulses.
*/
`timescale 1ns/1ps
`include "ethernet_mac_core_tx_map.svh"

module ethernet_mac_core_tx_core
(
  // apb
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // system memory read port
  output logic                        mem_req,
  output logic [31:0]                 mem_addr,
  input  wire logic                   mem_ack,
  input  wire logic [31:0]            mem_rdata,
  // transmit byte stream
  output logic                        tx_valid,
  output logic [7:0]                  tx_data,
  output logic                        tx_last,
  input  wire logic                   tx_ready,
  // receive side
  input  wire ethernet_mac_core_tx_pkg::ethernet_mac_core_irq_t ext_event,
  output logic [`ETHERNET_MAC_CORE_NUM_PAIRS-1:0]  match_en,
  // interrupt
  output logic                        irq
);
  import ethernet_mac_core_tx_pkg::*;

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  logic        setup;
  logic        access;
  logic        wr;
  logic        hit;
  logic        is_pair;
  logic [31:0] rd_val;
  logic [3:0]  pair_idx;

  logic                 txen_reg;
  logic [31:0]          tqptr_reg;
  ethernet_mac_core_irq_t            istat_reg;
  ethernet_mac_core_irq_t            istat_next;
  ethernet_mac_core_irq_t            imask_reg;
  ethernet_mac_core_irq_t            evt;
  logic [31:0]          pair_reg [0:2*`ETHERNET_MAC_CORE_NUM_PAIRS-1];
  ethernet_mac_core_state_t          st_reg;
  logic [31:0]          dptr_reg;
  logic [31:0]          baddr_reg;
  logic [31:0]          w1_reg;
  logic [10:0]          left_reg;
  logic [7:0]           nbuf_reg;
  logic                 ist_rd_reg;

  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign wr       = access && pwrite;
  assign is_pair  = (paddr >= `ETHERNET_MAC_CORE_OFS_PAIR0) &&
                    (paddr <= `ETHERNET_MAC_CORE_OFS_PAIR_END) && (paddr[1:0] == 2'b00);
  assign pair_idx = 4'((paddr - `ETHERNET_MAC_CORE_OFS_PAIR0) >> 2);
  assign pready   = 1'b1;

  always_comb
  begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    if (is_pair)
      rd_val = pair_reg[pair_idx];
    else
      unique case (paddr)
        `ETHERNET_MAC_CORE_OFS_NCTRL: rd_val[`ETHERNET_MAC_CORE_NCTRL_TXEN] = txen_reg;
        `ETHERNET_MAC_CORE_OFS_TQPTR: rd_val = dptr_reg;
        `ETHERNET_MAC_CORE_OFS_ISTAT: rd_val[`ETHERNET_MAC_CORE_NUM_IRQ-1:0] = istat_reg;
        `ETHERNET_MAC_CORE_OFS_IMASK: rd_val[`ETHERNET_MAC_CORE_NUM_IRQ-1:0] = imask_reg;
        `ETHERNET_MAC_CORE_OFS_MATCH: rd_val[`ETHERNET_MAC_CORE_NUM_PAIRS-1:0] = match_en;
        `ETHERNET_MAC_CORE_OFS_IENA, `ETHERNET_MAC_CORE_OFS_IDIS: rd_val = 32'h0000_0000;
        default: hit = 1'b0;
      endcase
  end

  // read data is captured in setup so it is stable through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata     <= 32'h0000_0000;
      pslverr    <= 1'b0;
      ist_rd_reg <= 1'b0;
    end
    else if (setup)
    begin
      prdata     <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr    <= !hit;
      ist_rd_reg <= !pwrite && (paddr == `ETHERNET_MAC_CORE_OFS_ISTAT);
    end
  end

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txen_reg  <= 1'b0;
      tqptr_reg <= 32'h0000_0000;
    end
    else if (wr && paddr == `ETHERNET_MAC_CORE_OFS_NCTRL)
      txen_reg  <= pwdata[`ETHERNET_MAC_CORE_NCTRL_TXEN];
    else if (wr && paddr == `ETHERNET_MAC_CORE_OFS_TQPTR)
      tqptr_reg <= {pwdata[31:2], 2'b00};
  end

  // ------------------------------------------------------------------
  // address filter pairs
  // ------------------------------------------------------------------
  // writes are taken in any state; reception has no say here
  genvar g;
  generate
    for (g = 0; g < `ETHERNET_MAC_CORE_NUM_PAIRS; g++)
    begin : g_pair
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pair_reg[2*g]   <= 32'h0000_0000;
          pair_reg[2*g+1] <= 32'h0000_0000;
          match_en[g]     <= 1'b0;
        end
        else if (wr && is_pair && pair_idx == 4'(2*g))
        begin
          pair_reg[2*g] <= pwdata;
          match_en[g]   <= 1'b0;
        end
        else if (wr && is_pair && pair_idx == 4'(2*g+1))
        begin
          pair_reg[2*g+1] <= {16'h0000, pwdata[15:0]};
          match_en[g]     <= 1'b1;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------------
  logic ev_used;
  logic ev_buferr;
  logic ev_done;

  always_comb
  begin
    evt                      = ext_event;
    evt[`ETHERNET_MAC_CORE_IRQ_USED]      = ext_event[`ETHERNET_MAC_CORE_IRQ_USED] | ev_used;
    evt[`ETHERNET_MAC_CORE_IRQ_BUFERR]    = ext_event[`ETHERNET_MAC_CORE_IRQ_BUFERR] | ev_buferr;
    evt[`ETHERNET_MAC_CORE_IRQ_TXDONE]    = ext_event[`ETHERNET_MAC_CORE_IRQ_TXDONE] | ev_done;
    // clear only what the read returned; a new event still lands
    istat_next = istat_reg;
    if (access && ist_rd_reg)
      istat_next = istat_reg & ~prdata[`ETHERNET_MAC_CORE_NUM_IRQ-1:0];
    istat_next = istat_next | evt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      istat_reg <= '0;
      imask_reg <= `ETHERNET_MAC_CORE_IMASK_RST;
    end
    else
    begin
      istat_reg <= istat_next;
      if (wr && paddr == `ETHERNET_MAC_CORE_OFS_IENA)
        imask_reg <= imask_reg & ~pwdata[`ETHERNET_MAC_CORE_NUM_IRQ-1:0];
      else if (wr && paddr == `ETHERNET_MAC_CORE_OFS_IDIS)
        imask_reg <= imask_reg | pwdata[`ETHERNET_MAC_CORE_NUM_IRQ-1:0];
    end
  end

  // mask bit one means disabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(istat_next & ~imask_reg);
  end

  // ------------------------------------------------------------------
  // descriptor walker
  // ------------------------------------------------------------------
  logic [10:0] len_w1;
  assign len_w1 = mem_rdata[`ETHERNET_MAC_CORE_D_LEN_MSB:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg    <= ETHERNET_MAC_CORE_IDLE;
      dptr_reg  <= 32'h0000_0000;
      baddr_reg <= 32'h0000_0000;
      w1_reg    <= 32'h0000_0000;
      left_reg  <= 11'h000;
      nbuf_reg  <= 8'h00;
      mem_req   <= 1'b0;
      mem_addr  <= 32'h0000_0000;
      tx_valid  <= 1'b0;
      tx_data   <= 8'h00;
      tx_last   <= 1'b0;
      ev_used   <= 1'b0;
      ev_buferr <= 1'b0;
      ev_done   <= 1'b0;
    end
    else
    begin
      ev_used   <= 1'b0;
      ev_buferr <= 1'b0;
      ev_done   <= 1'b0;
      if (wr && paddr == `ETHERNET_MAC_CORE_OFS_TQPTR)
        dptr_reg <= {pwdata[31:2], 2'b00};
      unique case (st_reg)
        ETHERNET_MAC_CORE_IDLE:
          if (txen_reg && !(wr && paddr == `ETHERNET_MAC_CORE_OFS_TQPTR))
          begin
            st_reg   <= ETHERNET_MAC_CORE_RD0;
            mem_req  <= 1'b1;
            mem_addr <= dptr_reg;
          end
        ETHERNET_MAC_CORE_RD0:
          if (mem_ack)
          begin
            baddr_reg <= mem_rdata;
            mem_addr  <= dptr_reg + 32'h0000_0004;
            st_reg    <= ETHERNET_MAC_CORE_RD1;
          end
        ETHERNET_MAC_CORE_RD1:
          if (mem_ack)
          begin
            w1_reg <= mem_rdata;
            if (mem_rdata[`ETHERNET_MAC_CORE_D_OWN])
            begin
              // software still holds it: back to idle, then re-read the same entry while enabled
              mem_req <= 1'b0;
              ev_used <= 1'b1;
              st_reg  <= ETHERNET_MAC_CORE_IDLE;
            end
            else if (len_w1 == 11'h000 ||
                     nbuf_reg == `ETHERNET_MAC_CORE_MAX_BUFS)
            begin
              mem_req   <= 1'b0;
              ev_buferr <= 1'b1;
              nbuf_reg  <= 8'h00;
              st_reg    <= ETHERNET_MAC_CORE_NEXT;
            end
            else
            begin
              left_reg <= len_w1;
              nbuf_reg <= nbuf_reg + 8'h01;
              mem_addr <= {baddr_reg[31:2], 2'b00};
              st_reg   <= ETHERNET_MAC_CORE_RDB;
            end
          end
        ETHERNET_MAC_CORE_RDB:
          if (mem_ack)
          begin
            // byte lane picked from the buffer address
            mem_req  <= 1'b0;
            tx_data  <= 8'(mem_rdata >> {baddr_reg[1:0], 3'b000});
            tx_last  <= (left_reg == 11'h001) && w1_reg[`ETHERNET_MAC_CORE_D_LAST];
            tx_valid <= 1'b1;
            st_reg   <= ETHERNET_MAC_CORE_SEND;
          end
        ETHERNET_MAC_CORE_SEND:
          if (tx_ready)
          begin
            tx_valid  <= 1'b0;
            tx_last   <= 1'b0;
            baddr_reg <= baddr_reg + 32'h0000_0001;
            left_reg  <= left_reg - 11'h001;
            if (left_reg != 11'h001)
            begin
              mem_req  <= 1'b1;
              mem_addr <= {baddr_reg[31:2] + 30'((baddr_reg[1:0] == 2'b11)),
                           2'b00};
              st_reg   <= ETHERNET_MAC_CORE_RDB;
            end
            else
            begin
              if (w1_reg[`ETHERNET_MAC_CORE_D_LAST])
              begin
                ev_done  <= 1'b1;
                nbuf_reg <= 8'h00;
              end
              st_reg <= ETHERNET_MAC_CORE_NEXT;
            end
          end
        ETHERNET_MAC_CORE_NEXT:
        begin
          if (w1_reg[`ETHERNET_MAC_CORE_D_WRAP])
            dptr_reg <= tqptr_reg;
          else
            dptr_reg <= dptr_reg + 32'h0000_0008;
          st_reg <= ETHERNET_MAC_CORE_IDLE;
        end
      endcase
      if (!txen_reg)
      begin
        // disabling stops at once and rewinds to the queue start
        st_reg   <= ETHERNET_MAC_CORE_IDLE;
        mem_req  <= 1'b0;
        tx_valid <= 1'b0;
        tx_last  <= 1'b0;
        nbuf_reg <= 8'h00;
        dptr_reg <= tqptr_reg;
      end
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb_pclk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_w1_wrap;
    st_reg == ETHERNET_MAC_CORE_NEXT && w1_reg[`ETHERNET_MAC_CORE_D_WRAP] && txen_reg;
  endsequence

  sequence s_w1_owned;
    st_reg == ETHERNET_MAC_CORE_RD1 && mem_ack && mem_rdata[`ETHERNET_MAC_CORE_D_OWN];
  endsequence

  sequence s_w1_bad;
    st_reg == ETHERNET_MAC_CORE_RD1 && mem_ack && !mem_rdata[`ETHERNET_MAC_CORE_D_OWN] && txen_reg &&
      (len_w1 == 11'h000 || nbuf_reg == `ETHERNET_MAC_CORE_MAX_BUFS);
  endsequence

  wrap_reload_a: assert property (
    s_w1_wrap |=> dptr_reg == $past(tqptr_reg))
    else $error("wrap did not return to queue pointer");
  owned_stop_a: assert property (
    s_w1_owned |=> st_reg == ETHERNET_MAC_CORE_IDLE && ev_used && !tx_valid)
    else $error("software-owned entry was not refused");
  bad_buf_a: assert property (
    s_w1_bad |=> st_reg == ETHERNET_MAC_CORE_NEXT && ev_buferr && !tx_valid)
    else $error("bad buffer was not skipped");
  txen_idle_a: assert property (
    !txen_reg && !$past(txen_reg) |-> st_reg == ETHERNET_MAC_CORE_IDLE && !mem_req)
    else $error("transmit active while disabled");
  bottom_dis_a: assert property (
    wr && is_pair && !pair_idx[0] |=> !match_en[$past(pair_idx[3:1])])
    else $error("bottom write left matching on");
  top_en_a: assert property (
    wr && is_pair && pair_idx[0] |=> match_en[$past(pair_idx[3:1])])
    else $error("top write did not re-enable matching");
  irq_or_a: assert property (
    irq == |($past(istat_next) & ~$past(imask_reg)))
    else $error("interrupt line disagrees with status");
  irq_hold_a: assert property (
    |(istat_reg & ~imask_reg) && !(access && ist_rd_reg) |=> irq)
    else $error("interrupt dropped while pending");
  rd_clear_a: assert property (
    access && ist_rd_reg && evt == '0
      |=> (istat_reg & $past(prdata[`ETHERNET_MAC_CORE_NUM_IRQ-1:0])) == '0)
    else $error("status read did not clear");
  ena_unmask_a: assert property (
    wr && paddr == `ETHERNET_MAC_CORE_OFS_IENA
      |=> (imask_reg & $past(pwdata[`ETHERNET_MAC_CORE_NUM_IRQ-1:0])) == '0)
    else $error("enable write did not unmask");
  dis_mask_a: assert property (
    wr && paddr == `ETHERNET_MAC_CORE_OFS_IDIS
      |=> (~imask_reg & $past(pwdata[`ETHERNET_MAC_CORE_NUM_IRQ-1:0])) == '0)
    else $error("disable write did not mask");
  buf_limit_a: assert property (
    nbuf_reg <= `ETHERNET_MAC_CORE_MAX_BUFS)
    else $error("frame buffer count above limit");

endmodule // ethernet_mac_core_tx_core

// ---- src/ethernet_mac_core_tx_map.svh ----
/*
  register offsets, field positions, reset values and limits of the
  ethernet_mac_core transmit queue, address filter and interrupt block.
  assumes: included by bare name from the package and the core module.
*/
`ifndef ETHERNET_MAC_CORE_TX_MAP_SVH
`define ETHERNET_MAC_CORE_TX_MAP_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define ETHERNET_MAC_CORE_OFS_NCTRL    8'h00
`define ETHERNET_MAC_CORE_OFS_TQPTR    8'h1C
`define ETHERNET_MAC_CORE_OFS_ISTAT    8'h24
`define ETHERNET_MAC_CORE_OFS_IENA     8'h28
`define ETHERNET_MAC_CORE_OFS_IDIS     8'h2C
`define ETHERNET_MAC_CORE_OFS_IMASK    8'h30
`define ETHERNET_MAC_CORE_OFS_PAIR0    8'h90
`define ETHERNET_MAC_CORE_OFS_PAIR_END 8'hB4
`define ETHERNET_MAC_CORE_OFS_MATCH    8'hC0

// ------------------------------------------------------------------
// fields
// ------------------------------------------------------------------
`define ETHERNET_MAC_CORE_NCTRL_TXEN   3
`define ETHERNET_MAC_CORE_D_OWN        31
`define ETHERNET_MAC_CORE_D_WRAP       30
`define ETHERNET_MAC_CORE_D_LAST       15
`define ETHERNET_MAC_CORE_D_LEN_MSB    10
`define ETHERNET_MAC_CORE_IRQ_USED     3
`define ETHERNET_MAC_CORE_IRQ_BUFERR   4
`define ETHERNET_MAC_CORE_IRQ_TXDONE   7

// ------------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------------
`define ETHERNET_MAC_CORE_IMASK_RST    14'h3FFF
`define ETHERNET_MAC_CORE_MAX_LEN      11'h7FF
`define ETHERNET_MAC_CORE_MAX_BUFS     8'h80
`define ETHERNET_MAC_CORE_NUM_IRQ      14
`define ETHERNET_MAC_CORE_NUM_PAIRS    5

`endif

// ---- src/ethernet_mac_core_tx_pkg.sv ----
/*
  types of the ethernet_mac_core transmit queue block.
  assumes: ethernet_mac_core_tx_map.svh on the include path.
*/
`include "ethernet_mac_core_tx_map.svh"

package ethernet_mac_core_tx_pkg;

  // gray codes along idle -> word0 -> word1 -> byte -> send -> next
  typedef enum logic [2:0]
  {
    ETHERNET_MAC_CORE_IDLE = 3'b000,
    ETHERNET_MAC_CORE_RD0  = 3'b001,
    ETHERNET_MAC_CORE_RD1  = 3'b011,
    ETHERNET_MAC_CORE_RDB  = 3'b010,
    ETHERNET_MAC_CORE_SEND = 3'b110,
    ETHERNET_MAC_CORE_NEXT = 3'b111
  } ethernet_mac_core_state_t;

  typedef logic [`ETHERNET_MAC_CORE_NUM_IRQ-1:0] ethernet_mac_core_irq_t;

endpackage

// ---- testbench/ethernet_mac_core_mem_model.sv ----
/*
  behavioural system memory that answers the core's descriptor and data
  reads, one word per request, promptly or after a few idle cycles.
  assumes: one outstanding read; mem_req and mem_addr held until mem_ack.
*/
`timescale 1ns/1ps

module ethernet_mac_core_mem_model
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // read port
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  // pacing
  input  wire logic        slow
);
  // ------------------------------------------------------------------
  // storage: descriptor pairs and frame data, loaded by the bench
  // ------------------------------------------------------------------
  logic [31:0] words [0:255];
  logic [1:0]  wait_reg;

  // word1 carries owner, wrap, last and length
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      wait_reg  <= 2'h0;
    end
    else if (mem_req && !mem_ack && (!slow || wait_reg == 2'h3))
    begin
      mem_ack   <= 1'b1;
      mem_rdata <= words[mem_addr[9:2]];
      wait_reg  <= 2'h0;
    end
    else
    begin
      mem_ack   <= 1'b0;
      // lines churn between answers so a stale word is never mistaken
      mem_rdata <= ~mem_rdata;
      wait_reg  <= (mem_req && !mem_ack) ? wait_reg + 2'h1 : 2'h0;
    end
  end
endmodule // ethernet_mac_core_mem_model

// ---- testbench/mac_tx_queue_addr_match_irq_test.sv ----
/*
  self-checking bench: apb register access, interrupt combine, filter
  pairs and one scattered frame through the descriptor queue.
  assumes: ethernet_mac_core_tx_pkg compiled first; memory model beside the core.
*/
`timescale 1ns/1ps
`include "ethernet_mac_core_tx_map.svh"

`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module mac_tx_queue_addr_match_irq_test;
  import ethernet_mac_core_tx_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, tx_data;
  logic [31:0] pwdata, prdata, mem_addr, mem_rdata, rdata, acc;
  logic        mem_req, mem_ack, tx_valid, tx_last, tx_ready, irq, slow;
  logic        rerr;
  logic [4:0]  match_en;
  ethernet_mac_core_irq_t   ext_event;
  int          fail_count, samples_checked, cycles;

  ethernet_mac_core_tx_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .ext_event(ext_event),
    .match_en(match_en), .irq(irq));

  ethernet_mac_core_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .slow(slow));

  // ------------------------------------------------------------------
  // clock, timeout and verdict
  // ------------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic final_report();
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // the whole run needs a few hundred cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  // ------------------------------------------------------------------
  // apb master and helpers
  // ------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for the answer
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdata, exp)
  endtask

  task automatic pulse(input ethernet_mac_core_irq_t v);
    @(posedge pclk);
    ext_event <= v;
    @(posedge pclk);
    ext_event <= 14'h0000;
  endtask

  function automatic logic [7:0] byte_at(input int a);
    return 8'(a) ^ 8'hA5;
  endfunction

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    `CHK(irq, 1'b0)
    rd(`ETHERNET_MAC_CORE_OFS_IMASK, 32'h0000_3FFF);
    rd(8'h04, 32'h0000_0000);
    `CHK(rerr, 1'b1)
  endtask

  task automatic t_irq();
    int i;
    wr(`ETHERNET_MAC_CORE_OFS_IENA, 32'h0000_0020);
    rd(`ETHERNET_MAC_CORE_OFS_IMASK, 32'h0000_3FDF);
    pulse(14'h0220);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b1)
    rd(`ETHERNET_MAC_CORE_OFS_ISTAT, 32'h0000_0220);
    rd(`ETHERNET_MAC_CORE_OFS_ISTAT, 32'h0000_0000);
    `CHK(irq, 1'b0)
    wr(`ETHERNET_MAC_CORE_OFS_IDIS, 32'h0000_0020);
    pulse(14'h0020);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
    rd(`ETHERNET_MAC_CORE_OFS_ISTAT, 32'h0000_0020);
    wr(`ETHERNET_MAC_CORE_OFS_IENA, 32'h0000_3FFF);
    rd(`ETHERNET_MAC_CORE_OFS_IMASK, 32'h0000_0000);
    for (i = 0; i < `ETHERNET_MAC_CORE_NUM_IRQ; i++)
    begin
      pulse(14'h0001 << i);
      repeat (2) @(posedge pclk);
      `CHK(irq, 1'b1)
      rd(`ETHERNET_MAC_CORE_OFS_ISTAT, 32'h0000_0001 << i);
    end
    wr(`ETHERNET_MAC_CORE_OFS_IDIS, 32'h0000_3FFF);
    rd(`ETHERNET_MAC_CORE_OFS_IMASK, 32'h0000_3FFF);
  endtask

  task automatic t_pairs();
    int k;
    for (k = 0; k < `ETHERNET_MAC_CORE_NUM_PAIRS; k++)
    begin
      wr(`ETHERNET_MAC_CORE_OFS_PAIR0 + 8'(8 * k), 32'h1234_5678);
      rd(`ETHERNET_MAC_CORE_OFS_MATCH, 32'((1 << k) - 1));
      wr(`ETHERNET_MAC_CORE_OFS_PAIR0 + 8'(8 * k + 4), 32'h0000_9ABC);
      rd(`ETHERNET_MAC_CORE_OFS_MATCH, 32'((2 << k) - 1));
    end
    wr(`ETHERNET_MAC_CORE_OFS_PAIR0 + 8'h10, 32'h0000_0000);
    rd(`ETHERNET_MAC_CORE_OFS_MATCH, 32'h0000_001B);
    `CHK(match_en, 5'h1B)
    rd(`ETHERNET_MAC_CORE_OFS_PAIR0, 32'h1234_5678);
  endtask

  // three bytes at an odd address, an empty buffer, one byte elsewhere
  task automatic t_tx();
    int i, n, got;
    for (i = 128; i < 256; i++)
      u_mem.words[i] = {byte_at(4 * i + 3), byte_at(4 * i + 2),
                        byte_at(4 * i + 1), byte_at(4 * i)};
    u_mem.words[64] = 32'h0000_0201;
    u_mem.words[65] = 32'h0000_0003;
    u_mem.words[66] = 32'h0000_0280;
    u_mem.words[67] = 32'h0000_0000;
    u_mem.words[68] = 32'h0000_0302;
    u_mem.words[69] = 32'h4000_8001;
    wr(`ETHERNET_MAC_CORE_OFS_TQPTR, 32'h0000_0100);
    repeat (10) @(posedge pclk);
    `CHK(mem_req, 1'b0)
    wr(`ETHERNET_MAC_CORE_OFS_NCTRL, 32'h0000_0008);
    n = 0;
    got = 0;
    while (got < 4 && n < 2000)
    begin
      @(posedge pclk);
      n++;
      if (tx_valid === 1'b1 && tx_ready)
      begin
        `CHK(tx_data, byte_at(got < 3 ? 12'h201 + got : 12'h302))
        `CHK(tx_last, got == 3)
        got++;
        slow <= 1'b1;
      end
      tx_ready <= (n % 3 != 0);
    end
    `CHK(got, 4)
    // hand the first entry back to software so the walker parks there
    u_mem.words[65][31] = 1'b1;
    n = 0;
    while (mem_req !== 1'b1 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK(mem_addr, 32'h0000_0100)
    acc = 32'h0000_0000;
    n = 0;
    while (acc[3] !== 1'b1 && n < 50)
    begin
      apb(1'b0, `ETHERNET_MAC_CORE_OFS_ISTAT, 32'h0000_0000);
      acc = acc | rdata;
      n++;
    end
    `CHK(acc, 32'h0000_0098)
    rd(`ETHERNET_MAC_CORE_OFS_TQPTR, 32'h0000_0100);
    wr(`ETHERNET_MAC_CORE_OFS_NCTRL, 32'h0000_0000);
    repeat (10) @(posedge pclk);
    `CHK(mem_req, 1'b0)
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    fail_count      = 0;
    samples_checked = 0;
    cycles          = 0;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    tx_ready  = 1'b1;
    ext_event = 14'h0000;
    slow      = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_irq();
    t_pairs();
    t_tx();
    final_report();
  end
endmodule // mac_tx_queue_addr_match_irq_test
